/* rtl/rtas_slots.sv */
// Remote target address slots with alias remap and APB register access
//
// Notes on behaviour
// - Slots hold 7-bit address in 7:1, reset zero
// - Alias match substitutes slot's physical address
// - Substitution happens before control channel send
// - Slots 1-4 at indices 9h-Ch, aliases 1-4 at indices 11h-14h
// - Zero alias disables forwarding for that slot
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "rtas_cfg.svh"

module rtas_slots
#(
  parameter int NUM_SLOTS = `RTAS_NUM_SLOTS
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Local bus transaction in
  input wire rtas_pkg::rtas_xact_s LOCAL_XACT,
  output logic LOCAL_READY,
  // Toward the control channel
  output rtas_pkg::rtas_xact_s CHAN_XACT,
  input wire logic CHAN_READY,
  output rtas_pkg::rtas_fwd_e LAST_FWD
);
  import rtas_pkg::*;

  // ********************************************************
  // Register bus decode
  // ********************************************************
  logic [7:0] slot [NUM_SLOTS];
  logic [7:0] alias_r [NUM_SLOTS];
  logic [7:0] status;
  logic [31:0] next_prdata;
  wire [9:0] idx = PADDR[11:2];
  wire aligned = (PADDR[1:0] == 2'b00);
  wire access = PSEL && PENABLE;
  wire wr = access && PWRITE && PSTRB[0];
  wire [7:0] slot_idx [4] = '{`RTAS_IDX_SLOT1, `RTAS_IDX_SLOT2,
                              `RTAS_IDX_SLOT3, `RTAS_IDX_SLOT4};
  wire [7:0] alias_idx [4] = '{`RTAS_IDX_ALIAS1, `RTAS_IDX_ALIAS2,
                               `RTAS_IDX_ALIAS3, `RTAS_IDX_ALIAS4};
  logic [NUM_SLOTS-1:0] hit_slot;
  logic [NUM_SLOTS-1:0] hit_alias;
  wire hit_status = aligned && (idx == {2'b00, `RTAS_IDX_STATUS});
  wire mapped = (|hit_slot) || (|hit_alias) || hit_status;

  // Zero-wait slave: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      hit_slot[i] = aligned && (idx == {2'b00, slot_idx[i]});
      hit_alias[i] = aligned && (idx == {2'b00, alias_idx[i]});
      if (hit_slot[i])
        next_prdata = {24'h00_0000, slot[i]};
      else if (hit_alias[i])
        next_prdata = {24'h00_0000, alias_r[i]};
    end
    if (hit_status)
      next_prdata = {24'h00_0000, status};
  end

  // ********************************************************
  // Slot and alias storage
  // ********************************************************
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        slot[i] <= `RTAS_SLOT_RESET;
        alias_r[i] <= `RTAS_ALIAS_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        // Slot bit 0 is stored as written; it reads back but never remaps. Alias bit 0 is stored as zero
        if (wr && hit_slot[i])
          slot[i] <= PWDATA[7:0];
        if (wr && hit_alias[i])
          alias_r[i] <= {PWDATA[7:1], 1'b0};
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= next_prdata;
  end

  // ********************************************************
  // Alias match and address substitution
  // ********************************************************
  logic [NUM_SLOTS-1:0] match;
  logic [6:0] sub_addr;
  always_comb
  begin
    sub_addr = LOCAL_XACT.addr;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
    begin
      // Zero alias never matches, so the slot stays dormant
      match[i] = (alias_r[i][`RTAS_ADDR_MSB:`RTAS_ADDR_LSB] != 7'h00) &&
        (alias_r[i][`RTAS_ADDR_MSB:`RTAS_ADDR_LSB] ==
         LOCAL_XACT.addr);
      if (match[i])
        sub_addr = slot[i][`RTAS_ADDR_MSB:`RTAS_ADDR_LSB];
    end
  end

  wire any_match = |match;
  wire chan_free = !CHAN_XACT.valid || CHAN_READY;
  assign LOCAL_READY = chan_free;
  wire take = LOCAL_XACT.valid && chan_free;

  // Registered so the channel only ever sees the rewritten address
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      CHAN_XACT <= '0;
    else if (chan_free)
    begin
      CHAN_XACT.valid <= take && any_match;
      CHAN_XACT.addr <= sub_addr;
      CHAN_XACT.rnw <= LOCAL_XACT.rnw;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      LAST_FWD <= RTAS_FWD_NONE;
    else if (take)
      LAST_FWD <= any_match ? RTAS_FWD_MAPPED : RTAS_FWD_DROPPED;
  end

  assign status = {6'h00, LAST_FWD};

endmodule

/* rtl/rtas_cfg.svh */
// Offsets, field positions and reset values for the target address slots
`ifndef RTAS_CFG_SVH
`define RTAS_CFG_SVH

// Printed offsets are register indices; byte address is four times index
`define RTAS_IDX_SLOT1 8'h09
`define RTAS_IDX_SLOT2 8'h0A
`define RTAS_IDX_SLOT3 8'h0B
`define RTAS_IDX_SLOT4 8'h0C
// Alias registers are not printed here; our own indices
`define RTAS_IDX_ALIAS1 8'h11
`define RTAS_IDX_ALIAS2 8'h12
`define RTAS_IDX_ALIAS3 8'h13
`define RTAS_IDX_ALIAS4 8'h14
`define RTAS_IDX_STATUS 8'h20
`define RTAS_ADDR_MSB 7
`define RTAS_ADDR_LSB 1
`define RTAS_SLOT_RESET 8'h00
`define RTAS_ALIAS_RESET 8'h00
`define RTAS_NUM_SLOTS 4

`endif

/* rtl/rtas_pkg.sv */
// Types for the remote target address slots block
package rtas_pkg;

  // Local bus transaction header heading across the control channel
  typedef struct packed
  {
    logic valid;
    logic [6:0] addr;
    logic rnw;
  } rtas_xact_s;

  typedef enum logic [1:0]
  {
    RTAS_FWD_NONE = 2'b00,
    RTAS_FWD_MAPPED = 2'b01,
    RTAS_FWD_DROPPED = 2'b10
  } rtas_fwd_e;

endpackage

/* dv/rtas_slots_chk.sv */
// Assertions on the slot block ports
`timescale 1ns/10ps
module rtas_slots_chk
(
  input wire logic CLK, RESETN, PSEL, PENABLE, PWRITE, PSLVERR,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire rtas_pkg::rtas_xact_s LOCAL_XACT, CHAN_XACT,
  input wire logic LOCAL_READY, CHAN_READY,
  input wire rtas_pkg::rtas_fwd_e LAST_FWD
);
  import rtas_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire tk = LOCAL_XACT.valid && LOCAL_READY;
  wire st = CHAN_XACT.valid && !CHAN_READY;
  wire ac = PSEL && PENABLE;
  hold_hdr_a: assert property (st |=> $stable(CHAN_XACT))
    else $error("header moved");
  refuse_a: assert property (st |-> !LOCAL_READY)
    else $error("taken in stall");
  zero_alias_a: assert property (tk && LOCAL_XACT.addr == 7'h00
    |=> LAST_FWD == RTAS_FWD_DROPPED) else $error("zero forwarded");
  map_flag_a: assert property (tk |=> CHAN_XACT.valid ==
    (LAST_FWD == RTAS_FWD_MAPPED)) else $error("flag wrong");
  slot_ok_a: assert property (ac && PADDR inside {12'h024,
    12'h028, 12'h02C, 12'h030} |-> !PSLVERR) else $error("slot refused");
  upper_zero_a: assert property (ac && !PWRITE |->
    PRDATA[31:8] == 24'h0) else $error("upper bits");
  cover property (tk ##1 CHAN_XACT.valid);
  cover property (st [*2]);
  cover property (ac && PSLVERR);
endmodule

bind rtas_slots rtas_slots_chk u_chk(.CLK(CLK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PSLVERR(PSLVERR),
  .PADDR(PADDR), .PRDATA(PRDATA), .LOCAL_XACT(LOCAL_XACT),
  .CHAN_XACT(CHAN_XACT), .LOCAL_READY(LOCAL_READY),
  .CHAN_READY(CHAN_READY), .LAST_FWD(LAST_FWD));

/* dv/rtas_chan_sink.sv */
// Control channel far end, stalls at random
`timescale 1ns/10ps
module rtas_chan_sink
(
  input wire logic clk,
  output logic ready = 1'b0
);
  integer seed = 61;
  always @(posedge clk)
    ready <= $random(seed) & 1;
endmodule

/* dv/test_rtas_slots.sv */
// Self-checking bench for the target address slots
`timescale 1ns/10ps
module test_rtas_slots;
  import rtas_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic cr, pready, err, lr, re;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  rtas_xact_s lx = '0, cx;
  rtas_fwd_e lf;
  int fails = 0, checks = 0, cyc = 0, seed = 60;
  logic [7:0] slot [4];
  always #2.5 clk = ~clk;
  rtas_slots dut(.CLK(clk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'h1), .PRDATA(prdata), .PREADY(pready), .PSLVERR(err),
    .LOCAL_XACT(lx), .LOCAL_READY(lr), .CHAN_XACT(cx), .CHAN_READY(cr),
    .LAST_FWD(lf));
  rtas_chan_sink sink(.clk(clk), .ready(cr));
  task check(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("fails %0d checks %0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    re = err;
    psel <= 0;
    penable <= 0;
  endtask
  // Released header shows inverted address, not the old one
  task send(input logic [6:0] a, exp, input logic hit);
    @(posedge clk);
    lx <= '{1'b1, a, hit};
    // Ready is settled mid-cycle; the next rising edge takes the header
    do @(negedge clk); while (!lr);
    @(posedge clk);
    lx <= '{1'b0, ~a, 1'b0};
    #1 check(lf, hit ? RTAS_FWD_MAPPED : RTAS_FWD_DROPPED);
    if (hit) check({cx.valid, cx.addr, cx.rnw}, {1'b1, exp, 1'b1});
  endtask
  always @(posedge clk)
    if (++cyc > 3000)
    begin
      fails++;
      summarize;
    end
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 12'h024 + 4 * i, 0);
      check(rd, 0);
      slot[i] = $random(seed);
      apb(1, 12'h024 + 4 * i, slot[i]);
      apb(1, 12'h044 + 4 * i, 8'h20 + 2 * i);
      apb(0, 12'h024 + 4 * i, 0);
      check(rd, {24'h0, slot[i]});
    end
    // Bit 0 of each slot is random, so the remap must drop it
    for (int i = 0; i < 4; i++)
      send(7'h10 + i, slot[i][7:1], 1);
    apb(1, 12'h044, 0);
    send(7'h10, 0, 0);
    send(7'h00, 0, 0);
    apb(0, 12'h034, 0);
    check(re, 1);
    check(rd, 0);
    summarize;
  end
endmodule
